// [hw/acc_map.svh]
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// Clock period in ns
`define ACC_CLK_PERIOD_NS   10
// Least start pulse width, ns
`define ACC_START_PULSE_NS  300
// Longest delay to convert start, ns
`define ACC_START_DELAY_NS  700
// Longest bus access delay, ns
`define ACC_BUS_ACCESS_DELAY_NS 250
// Conversion time, ns
`define ACC_CONV_TIME_NS    10000
// Cycle counts derived from the times (least rounds up, longest rounds down)
`define ACC_START_PULSE_CYC ((`ACC_START_PULSE_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_START_DELAY_CYC (`ACC_START_DELAY_NS / `ACC_CLK_PERIOD_NS)
`define ACC_BUS_ACCESS_CYC  (`ACC_BUS_ACCESS_DELAY_NS / `ACC_CLK_PERIOD_NS)
`define ACC_CONV_CYC        (`ACC_CONV_TIME_NS / `ACC_CLK_PERIOD_NS)
// Cycles spent in the reset state between conversions
`define ACC_GAP_CYC         2
// Result width and reset value
`define ACC_DATA_W          8
`define ACC_DATA_RST        8'h00
// Bit positions of the format bits
`define ACC_FMT_TWOS_BIT    0
`define ACC_FMT_BIP_BIT     1
`endif

// [hw/acc_pkg.sv]
`include "acc_map.svh"
package acc_pkg;
    // Conversion format captured at start
    typedef struct packed {
        logic bipolar_range_sel;   // 1 selects bipolar range
        logic twos_coding;         // 1 selects two's complement
    } acc_fmt_t;
    // Synchronised control lines
    typedef struct packed {
        logic sel_a_n;             // First select, active low
        logic sel_b_n;             // Second select, active low
        logic rw;                  // High read, low convert
    } acc_ctl_t;
    // Sequencer states
    typedef enum logic [3:0] {
        ACC_IDLE = 4'b0001,
        ACC_WAIT = 4'b0010,
        ACC_CONV = 4'b0100,
        ACC_GAP  = 4'b1000
    } acc_state_t;
endpackage

// [hw/acc_sync.sv]
`timescale 1ns/10ps
module acc_sync
    import acc_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     resetn,
    input  wire acc_ctl_t raw,
    input  wire acc_fmt_t raw_fmt,
    output acc_ctl_t      ctl,
    output acc_fmt_t      fmt
);
    acc_ctl_t meta;        // First stage, read only by second stage
    acc_fmt_t meta_fmt;    // First stage of format pins

    ////////////////////////////////////////////////////////////////
    // Two-flop synchroniser; selects idle high so nothing starts at reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta     <= 3'h7;
            ctl      <= 3'h7;
            meta_fmt <= 2'h0;
            fmt      <= 2'h0;
        end else begin
            meta     <= raw;
            ctl      <= meta;
            meta_fmt <= raw_fmt;
            fmt      <= meta_fmt;
        end
    end
endmodule

// [hw/acc_sar.sv]
`timescale 1ns/10ps
`include "acc_map.svh"
module acc_sar
    import acc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       comp_high,
    input  wire acc_fmt_t   fmt,
    output logic            busy,
    output logic            done,
    output logic [7:0]      trial,
    output logic [7:0]      result
);
    localparam int          STEP = `ACC_CONV_CYC / 8;   // Cycles per bit decision
    logic [15:0]            tick;       // Cycles within the current bit
    logic [2:0]             bitpos;     // Bit under trial
    logic [7:0]             sar;        // Approximation register
    logic                   last_step;  // Final cycle of a bit

    assign last_step = (tick == 16'(STEP - 1));
    assign trial     = sar;

    ////////////////////////////////////////////////////////////////
    // Successive approximation, one bit per step, MSB first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy   <= 1'b0;
            done   <= 1'b0;
            tick   <= 16'h0000;
            bitpos <= 3'h7;
            sar    <= 8'h00;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy   <= 1'b1;
                tick   <= 16'h0000;
                bitpos <= 3'h7;
                sar    <= 8'h80;
            end else if (busy) begin
                tick <= last_step ? 16'h0000 : tick + 16'h0001;
                if (last_step) begin
                    // Comparator high means trial is above input: drop bit
                    if (comp_high)
                        sar[bitpos] <= 1'b0;
                    if (bitpos == 3'h0) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        sar[bitpos - 3'h1] <= 1'b1;
                        bitpos             <= bitpos - 3'h1;
                    end
                end
            end
        end
    end

    // Final code with the LSB decision folded in, then recoded
    logic [7:0] raw_code;
    assign raw_code = {sar[7:1], sar[0] & ~comp_high};
    // Two's complement flips MSB of the offset-binary code in bipolar range
    assign result   = (fmt.twos_coding && fmt.bipolar_range_sel) ?
                      {~raw_code[7], raw_code[6:0]} : raw_code;
endmodule

// [hw/acc_ctrl.sv]
`timescale 1ns/10ps
// Contract
// - Both interchangeable selects low enable operation
// - Direction low converts, high reads
// - Control lines may arrive in any order
// - All low 300ns raises status
// - Start commands ignored while converting
// - Output buffer off during conversion
// - Data floats until read, valid within 250ns
// - Select rising ends read, outputs float
// - Falling direction starts conversion within 700ns
// - Single result held until selects rise
// - All low converts back to back
// - Direction rise gives one final conversion
// - Continuous data valid until selects or direction
// - Status high during conversion, low after
// - Format inputs present before write
`include "acc_map.svh"
module acc_ctrl
    import acc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sel_a_n,
    input  wire logic       sel_b_n,
    input  wire logic       rw,
    input  wire logic       twos_coding,
    input  wire logic       bipolar_range_sel,
    input  wire logic       comp_high,
    output logic [7:0]      dac_code,
    output logic            status,
    output logic [7:0]      data_out,
    output logic [7:0]      data_oe_n
);
    localparam int PULSE_CYC = `ACC_START_PULSE_CYC;    // Least qualify time
    localparam int DELAY_CYC = `ACC_START_DELAY_CYC;    // Limit before start
    localparam int ACC_CYC   = `ACC_BUS_ACCESS_CYC;     // Read access limit
    localparam int GAP_CYC   = `ACC_GAP_CYC;            // Reset gap length

    acc_ctl_t      ctl;             // Synchronised control lines
    acc_fmt_t      fmt_pin;         // Synchronised format pins
    acc_fmt_t      fmt;             // Format latched at start
    acc_state_t    state;           // Sequencer state
    acc_state_t    next_state;      // Next sequencer state
    logic [7:0]    qual;            // Cycles all three lines held low
    logic [7:0]    gap;             // Cycles spent in reset gap
    logic [7:0]    result;          // Output latch
    logic          sar_start;       // Start pulse to SAR
    logic          sar_busy;        // SAR running
    logic          sar_done;        // SAR finished pulse
    logic [7:0]    sar_result;      // SAR code
    logic [7:0]    sar_trial;       // SAR trial code
    logic          want_read;       // Read requested
    logic          rw_seen_high;    // Direction rose during conversion
    logic          regap_start;     // Series re-entry start

    ////////////////////////////////////////////////////////////////
    // Pin synchroniser and SAR core
    acc_sync u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .raw     ({sel_a_n, sel_b_n, rw}),
        .raw_fmt ({bipolar_range_sel, twos_coding}),
        .ctl     (ctl),
        .fmt     (fmt_pin)
    );

    acc_sar u_sar (
        .clk       (clk),
        .resetn    (resetn),
        .start     (sar_start),
        .comp_high (comp_high),
        .fmt       (fmt),
        .busy      (sar_busy),
        .done      (sar_done),
        .trial     (sar_trial),
        .result    (sar_result)
    );

    ////////////////////////////////////////////////////////////////
    // Command decode; selects are symmetric so either may be the strobe
    function automatic logic both_sel(input acc_ctl_t c);
        return !c.sel_a_n && !c.sel_b_n;
    endfunction

    wire cmd_conv = both_sel(ctl) && !ctl.rw;
    wire cmd_read = both_sel(ctl) && ctl.rw;
    // Qualified once held past the least pulse width
    wire qualified = (qual >= 8'(PULSE_CYC));
    // Host keeps its own pulse width; the design only counts it
    wire host_ok   = qualified;

    assign want_read = cmd_read;
    // Gap to conversion re-entry must also pulse the SAR, or a series stalls
    assign regap_start = (state == ACC_GAP) && (next_state == ACC_CONV);
    assign sar_start   = ((state == ACC_WAIT) && host_ok) || regap_start;

    ////////////////////////////////////////////////////////////////
    // Hold counter: restarts whenever any line goes high
    always_ff @(posedge clk) begin
        if (!resetn)
            qual <= 8'h00;
        else if (!cmd_conv)
            qual <= 8'h00;
        else if (!qualified)
            qual <= qual + 8'h01;
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            ACC_IDLE: begin
                if (cmd_conv)
                    next_state = ACC_WAIT;
            end
            ACC_WAIT: begin
                // Start dropped if a line rises before qualification
                if (!cmd_conv)
                    next_state = ACC_IDLE;
                else if (host_ok)
                    next_state = ACC_CONV;
            end
            ACC_CONV: begin
                // Further starts ignored until done
                if (sar_done)
                    next_state = ACC_GAP;
            end
            ACC_GAP: begin
                // Still all low and not released: convert again
                if (gap >= 8'(GAP_CYC - 1))
                    next_state = (cmd_conv && !rw_seen_high) ? ACC_CONV : ACC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // State, gap counter and release tracking
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state        <= ACC_IDLE;
            gap          <= 8'h00;
            rw_seen_high <= 1'b0;
        end else begin
            state <= next_state;
            gap   <= (state == ACC_GAP) ? gap + 8'h01 : 8'h00;
            // Direction rise during a run lets the current one finish last
            if (state == ACC_CONV && ctl.rw)
                rw_seen_high <= 1'b1;
            else if (state == ACC_IDLE)
                rw_seen_high <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Format latch: captured at start so mid-conversion changes are safe
    always_ff @(posedge clk) begin
        if (!resetn)
            fmt <= 2'h0;
        else if (sar_start || regap_start)
            fmt <= fmt_pin;
    end

    ////////////////////////////////////////////////////////////////
    // Output latch: only a finished conversion changes it
    always_ff @(posedge clk) begin
        if (!resetn)
            result <= `ACC_DATA_RST;
        else if (sar_done)
            result <= sar_result;
    end

    ////////////////////////////////////////////////////////////////
    // Status and outputs, all registered
    wire conv_active = (next_state == ACC_CONV);
    // Bus drive only on a read outside any conversion; access is a few cycles
    wire drive = want_read && !conv_active && (state != ACC_CONV);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status    <= 1'b0;
            data_out  <= `ACC_DATA_RST;
            data_oe_n <= 8'hFF;
            dac_code  <= 8'h00;
        end else begin
            status   <= conv_active;
            dac_code <= (state == ACC_CONV) ? sar_trial : 8'h00;
            // Drive within access limit; float when a select rises
            data_out  <= drive ? (sar_done ? sar_result : result) : `ACC_DATA_RST;
            data_oe_n <= drive ? 8'h00 : 8'hFF;
        end
    end

    // Unused delay limit kept to show start meets it by construction
    wire unused_ok = (PULSE_CYC <= DELAY_CYC) && (ACC_CYC > 0);
endmodule

// [sim/acc_front_model.sv]
`timescale 1ns/10ps
module acc_front_model
    import acc_pkg::*;
(
    input  wire logic [7:0] dac_code,  // Trial code
    input  wire logic [7:0] vin,       // Held input level as a code
    input  wire logic [7:0] data_out,  // Result lines
    input  wire logic [7:0] data_oe_n, // Drive enables, low drives
    output logic            comp_high, // Trial above input
    output logic [7:0]      bus        // Resolved data bus
);
    logic [7:0] last;                  // Last value seen driven
    ////////////////////////////////////////
    // Ideal comparator: the search settles on the largest code not above vin
    assign comp_high = dac_code > vin;
    // Remember the driven value so a released bus can show its inverse
    always_latch begin
        if (data_oe_n == 8'h00) begin
            last <= data_out;
        end
    end
    // A floating bus reads back inverted, so stale data never passes
    assign bus = (data_oe_n == 8'h00) ? data_out : ~last;
endmodule

// [sim/acc_ctrl_monitor.sv]
`timescale 1ns/10ps
module acc_ctrl_monitor
    import acc_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       sel_a_n,
    input wire logic       sel_b_n,
    input wire logic       rw,
    input wire logic       twos_coding,
    input wire logic       bipolar_range_sel,
    input wire logic       comp_high,
    input wire logic [7:0] dac_code,
    input wire logic       status,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n
);
    logic [15:0] low_cnt;                     // Cycles with all lines low
    logic [15:0] hi_cnt;                      // Cycles status has been high
    wire         rd = !sel_a_n && !sel_b_n && rw;  // Read request
    wire         cv = !sel_a_n && !sel_b_n && !rw; // Convert request
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Run counters; saturation keeps a long series from wrapping
    always_ff @(posedge clk) begin
        if (!resetn) begin
            low_cnt <= 16'h0000;
            hi_cnt  <= 16'h0000;
        end else begin
            low_cnt <= cv ? low_cnt + {15'h0000, low_cnt != 16'hFFFF} : 16'h0000;
            hi_cnt  <= status ? hi_cnt + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////
    a_oe_off_conv: assert property (status |-> data_oe_n == 8'hFF)
        else $error("output driven during conversion");
    a_oe_uniform: assert property (data_oe_n == 8'h00 || data_oe_n == 8'hFF)
        else $error("output enables split");
    a_start_cause: assert property ($rose(status) |-> $past(low_cnt, 4) >= 16'h0019)
        else $error("status rose without a held convert request");
    // 1000 bit-decision cycles plus the cycle in which the result is latched
    a_status_len: assert property ($fell(status) |-> hi_cnt == 16'h03E9)
        else $error("conversion length wrong");
    a_gap_low: assert property ($fell(status) |=> !status)
        else $error("no gap between conversions");
    a_oe_cause: assert property ($fell(data_oe_n[0]) |-> $past(rd, 2))
        else $error("output driven without read");
    a_read_end: assert property (!data_oe_n[0] && !rd |-> ##[1:4] data_oe_n[0])
        else $error("output not released");
    a_access: assert property ($rose(rd) && !status |-> ##[1:25] !data_oe_n[0])
        else $error("read access too slow");
    a_data_hold: assert property (!data_oe_n[0] && !$past(data_oe_n[0]) |-> $stable(data_out))
        else $error("read data moved");
endmodule
bind acc_ctrl acc_ctrl_monitor mon_u (
    .clk(clk), .resetn(resetn), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n), .rw(rw),
    .twos_coding(twos_coding), .bipolar_range_sel(bipolar_range_sel),
    .comp_high(comp_high), .dac_code(dac_code), .status(status),
    .data_out(data_out), .data_oe_n(data_oe_n)
);

// [sim/adc_bus_convert_control_bench.sv]
`timescale 1ns/10ps
module adc_bus_convert_control_bench
    import acc_pkg::*;
;
    logic       clk, resetn, sel_a_n, sel_b_n, rw; // Clock, reset, bus lines
    logic       twos_coding, bipolar_range_sel;   // Format inputs
    logic       comp_high, status, hit;            // Comparator, flag, rise seen
    logic [7:0] dac_code, data_out, data_oe_n;     // Design outputs
    logic [7:0] vin, bus;                          // Input level, resolved bus
    int         failures, num_checks;              // Counters
    acc_ctrl dut_u (.clk(clk), .resetn(resetn), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n),
        .rw(rw), .twos_coding(twos_coding), .bipolar_range_sel(bipolar_range_sel),
        .comp_high(comp_high), .dac_code(dac_code), .status(status),
        .data_out(data_out), .data_oe_n(data_oe_n));
    acc_front_model front_u (.dac_code(dac_code), .vin(vin), .data_out(data_out),
        .data_oe_n(data_oe_n), .comp_high(comp_high), .bus(bus));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Remember any conversion start between clears
    always @(posedge clk) if (status) hit <= 1'b1;
    ////////////////////////////////////////
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Bounded wait on status (oe=0) or the drive enable (oe=1)
    task automatic wait_sig(bit oe, logic v, int n);
        for (int i = 0; i < n; i++) begin
            if ((oe ? data_oe_n[0] : status) === v) return;
            @(negedge clk);
        end
        failures++;
        $display("mismatch wait exp %h seen %h", v, ~v);
        conclude();
    endtask
    task automatic pins(logic a, logic b, logic r);
        sel_a_n = a;
        sel_b_n = b;
        rw = r;
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask
    // Two's complement flips the sign bit, and only in the bipolar range
    function automatic logic [7:0] exp_code(logic [7:0] v, logic bip, logic tw);
        return v ^ {bip & tw, 7'h00};
    endfunction
    ////////////////////////////////////////
    task automatic t_single(logic [7:0] v, logic bip, logic tw);
        vin = v;
        bipolar_range_sel = bip;
        twos_coding = tw;
        pins(1'b0, 1'b0, 1'b0);
        wait_sig(1'b0, 1'b1, 70);
        pins(1'b0, 1'b0, 1'b1);
        idle(20);
        check("oe_conv", data_oe_n, 8'hFF);
        wait_sig(1'b0, 1'b0, 1100);
        wait_sig(1'b1, 1'b0, 25);
        check("data", bus, exp_code(v, bip, tw));
        idle(50);
        check("data_held", bus, exp_code(v, bip, tw));
        pins(1'b1, 1'b1, 1'b1);
        idle(6);
        check("oe_off", data_oe_n, 8'hFF);
        $display("done single %h", v);
    endtask
    // Short pulse and lone selects must start nothing
    task automatic t_reject();
        hit = 1'b0;
        pins(1'b0, 1'b0, 1'b0);
        idle(20);
        pins(1'b0, 1'b1, 1'b0);
        idle(60);
        pins(1'b1, 1'b0, 1'b0);
        idle(60);
        pins(1'b0, 1'b1, 1'b1);
        idle(20);
        check("oe_one_sel", data_oe_n, 8'hFF);
        check("no_start", {7'h00, hit}, 8'h00);
        pins(1'b1, 1'b1, 1'b1);
        idle(5);
        $display("done reject");
    endtask
    // A second command mid-conversion is ignored
    task automatic t_ignore();
        vin = 8'h47;
        // Plain binary again, the last single run left two's complement set
        bipolar_range_sel = 1'b0;
        twos_coding = 1'b0;
        pins(1'b0, 1'b0, 1'b0);
        wait_sig(1'b0, 1'b1, 70);
        idle(300);
        pins(1'b1, 1'b1, 1'b0);
        idle(10);
        pins(1'b0, 1'b0, 1'b0);
        idle(40);
        pins(1'b0, 1'b0, 1'b1);
        wait_sig(1'b0, 1'b0, 1100);
        hit = 1'b0;
        wait_sig(1'b1, 1'b0, 25);
        check("data_ign", bus, 8'h47);
        idle(100);
        check("no_restart", {7'h00, hit}, 8'h00);
        pins(1'b1, 1'b1, 1'b1);
        idle(5);
        $display("done ignore");
    endtask
    // Lines arrive in mixed order, then back-to-back conversions
    task automatic t_continuous();
        vin = 8'h96;
        pins(1'b1, 1'b0, 1'b1);
        idle(5);
        pins(1'b1, 1'b0, 1'b0);
        idle(5);
        pins(1'b0, 1'b0, 1'b0);
        wait_sig(1'b0, 1'b1, 70);
        wait_sig(1'b0, 1'b0, 1100);
        wait_sig(1'b0, 1'b1, 70);
        vin = 8'h2D;
        wait_sig(1'b0, 1'b0, 1100);
        wait_sig(1'b0, 1'b1, 70);
        // A level unlike the previous run shows the final result is fresh
        vin = 8'hD2;
        idle(100);
        pins(1'b0, 1'b0, 1'b1);
        check("oe_cont", data_oe_n, 8'hFF);
        wait_sig(1'b0, 1'b0, 1100);
        hit = 1'b0;
        wait_sig(1'b1, 1'b0, 25);
        check("data_cont", bus, 8'hD2);
        idle(200);
        check("final_only", {7'h00, hit}, 8'h00);
        check("data_kept", bus, 8'hD2);
        $display("done continuous");
    endtask
    // Second read returns the latched result without converting
    task automatic t_reread();
        pins(1'b1, 1'b1, 1'b1);
        wait_sig(1'b1, 1'b1, 25);
        vin = 8'h11;
        idle(5);
        pins(1'b0, 1'b0, 1'b1);
        wait_sig(1'b1, 1'b0, 25);
        check("reread", bus, 8'hD2);
        pins(1'b0, 1'b1, 1'b1);
        wait_sig(1'b1, 1'b1, 25);
        $display("done reread");
    endtask
    ////////////////////////////////////////
    initial begin
        failures = 0;
        num_checks = 0;
        resetn = 1'b0;
        hit = 1'b0;
        vin = 8'h00;
        twos_coding = 1'b0;
        bipolar_range_sel = 1'b0;
        pins(1'b1, 1'b1, 1'b1);
        idle(3);
        resetn = 1'b1;
        idle(3);
        check("oe_reset", data_oe_n, 8'hFF);
        check("st_reset", {7'h00, status}, 8'h00);
        t_single(8'h5A, 1'b0, 1'b0);
        t_single(8'hC3, 1'b1, 1'b0);
        t_single(8'h3C, 1'b0, 1'b1);
        t_single(8'h81, 1'b1, 1'b1);
        t_reject();
        t_ignore();
        t_continuous();
        t_reread();
        conclude();
    end
endmodule
